// *** counter_command_readback.sv ***
// Avalon-MM front end for the counter command, data port and read-back
// Functional notes
// - Third counter data port works as one byte or two successive bytes.
// - Writing the data port loads the bytes as the counter start value.
// - While latched data is unread, later latches of that kind are ignored.
// - Latched 16-bit count reads low byte first, then high byte.
// - Latched status reads first, then count bytes, regardless of latch order.
// - Write-only 8-bit command register holds select, access, mode, format.
// - Top command bits pick counter one, two, three, or read-back.
// - Access bits pick latch, low only, high only, or low then high.
// - Count latch command captures the count for the next read.
// - Mode bits choose one of the six counting modes or reserved code 6 or 7.
// - Format bit set counts decimal digits, clear counts 16-bit binary.
// - Both top bits set makes the write a read-back command.
// - Read-back bit 5 low latches counts, bit 4 low latches status.
// - Status byte: output, pending, access, mode, format fields.
// - Status pending bit set until the written count is taken.
`timescale 1ns/1ps
module counter_command_readback
  import counter_cmd_pkg::*;
(
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic [ADDR_W-1:0] address_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [DATA_W-1:0] writedata_i,
  input wire logic [3:0] byteenable_i,
  output logic [DATA_W-1:0] readdata_o,
  output logic waitrequest_o,
  output logic irq_o,
  input wire logic [15:0] live_count_i,
  input wire logic out_level_i,
  input wire logic count_taken_i,
  output logic [15:0] load_value_o,
  output logic load_strobe_o,
  output logic [2:0] mode_o,
  output logic decimal_format_o,
  output logic [1:0] access_o
);
  typedef struct packed {
    logic waitreq;
    logic [DATA_W-1:0] rdata;
    access_t acc;
    mode_t mode;
    logic bcd;
    logic null_pend;
    logic live_hi;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic irq;
  } top_state_t;
  top_state_t s_ff, nxt_s;

  logic [3:0] idx;
  logic req;
  logic commit;
  logic [7:0] wd;
  target_t target_timer_pick;
  access_t byte_access_pick;
  logic [2:0] counting_mode_pick;
  logic decimal_format_pick;
  logic cmd_wr;
  logic data_wr;
  logic data_rd;
  logic cfg_third;
  logic latch_count;
  logic latch_status;
  logic [7:0] status_byte;
  logic count_held;
  logic status_held;
  logic held_any;
  logic [7:0] held_byte;
  logic ignored;
  logic [7:0] live_byte;
  logic [7:0] data_byte;
  logic [IRQ_W-1:0] events;
  logic [IRQ_W-1:0] w1c;
  logic [15:0] wr_value;
  logic wr_strobe;
  logic [15:0] load_value_ff;
  logic load_strobe_ff;

  assign idx = address_i[IDX_HI:IDX_LO];
  assign req = read_i | write_i;
  // A request takes effect only at the edge where waitrequest is seen low
  assign commit = req & ~s_ff.waitreq;
  assign wd = writedata_i[7:0];

  // Command word fields
  assign target_timer_pick = target_t'(wd[SEL_HI:SEL_LO]);
  assign byte_access_pick = access_t'(wd[ACC_HI:ACC_LO]);
  assign counting_mode_pick = wd[MODE_HI:MODE_LO];
  assign decimal_format_pick = wd[BCD_BIT];

  // The command register has no read path; only byte lane 0 carries it
  assign cmd_wr = commit & write_i & (idx == IDX_CMD) & byteenable_i[0];
  assign data_wr = commit & write_i & (idx == IDX_DATA3) & byteenable_i[0];
  assign data_rd = commit & read_i & (idx == IDX_DATA3);

  // Commands for the first two counters belong to their own ports
  assign cfg_third = cmd_wr && target_timer_pick == SEL_THIRD &&
    byte_access_pick != ACC_LATCH;

  // Count latch or read-back; read-back bit 0 is reserved and ignored
  always_comb begin
    latch_count = 1'b0;
    latch_status = 1'b0;
    if (cmd_wr) begin
      case (target_timer_pick)
        SEL_THIRD: begin
          latch_count = (byte_access_pick == ACC_LATCH);
        end
        SEL_READBACK: begin
          latch_count = wd[RB_PICK3] & ~wd[RB_COUNT_N];
          latch_status = wd[RB_PICK3] & ~wd[RB_STATUS_N];
        end
        default: begin
          latch_count = 1'b0;
          latch_status = 1'b0;
        end
      endcase
    end
  end

  assign status_byte = {out_level_i, s_ff.null_pend, s_ff.acc, s_ff.mode, s_ff.bcd};

  readback_latch u_latch (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .latch_count_i(latch_count),
    .latch_status_i(latch_status),
    .live_count_i(live_count_i),
    .status_i(status_byte),
    .access_i(s_ff.acc),
    .pop_i(data_rd & held_any),
    .count_held_o(count_held),
    .status_held_o(status_held),
    .byte_o(held_byte),
    .ignored_o(ignored)
  );

  data_port_writer u_writer (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .wr_i(data_wr),
    .byte_i(wd),
    .access_i(s_ff.acc),
    .restart_i(cfg_third),
    .value_o(wr_value),
    .strobe_o(wr_strobe)
  );

  assign held_any = count_held | status_held;

  // Live reads follow the access setting; a pair reads low then high
  always_comb begin
    case (s_ff.acc)
      ACC_HIGH: live_byte = live_count_i[15:8];
      ACC_BOTH: live_byte = s_ff.live_hi ? live_count_i[15:8] : live_count_i[7:0];
      default: live_byte = live_count_i[7:0];
    endcase
  end
  assign data_byte = held_any ? held_byte : live_byte;

  assign events[IRQ_LOADED] = count_taken_i;
  assign events[IRQ_IGNORED] = ignored;
  // Only accepted latches flag; dropped ones flag the ignored bit instead
  assign events[IRQ_LATCHED] = (latch_count & ~count_held) | (latch_status & ~status_held);
  assign w1c = (commit && write_i && idx == IDX_IRQ_STAT && byteenable_i[0]) ?
    writedata_i[IRQ_W-1:0] : '0;

  always_comb begin
    nxt_s = s_ff;
    // One wait cycle per request; read data is captured with it
    if (req && s_ff.waitreq) begin
      nxt_s.waitreq = 1'b0;
      case (idx)
        IDX_DATA3: nxt_s.rdata = {24'h000000, data_byte};
        IDX_IRQ_STAT: nxt_s.rdata = {{(DATA_W-IRQ_W){1'b0}}, s_ff.irq_stat};
        IDX_IRQ_MASK: nxt_s.rdata = {{(DATA_W-IRQ_W){1'b0}}, s_ff.irq_mask};
        default: nxt_s.rdata = '0;
      endcase
    end else begin
      nxt_s.waitreq = 1'b1;
    end
    if (cfg_third) begin
      nxt_s.acc = byte_access_pick;
      nxt_s.mode = mode_t'(counting_mode_pick);
      nxt_s.bcd = decimal_format_pick;
      nxt_s.live_hi = 1'b0;
    end else if (data_rd && !held_any && s_ff.acc == ACC_BOTH) begin
      nxt_s.live_hi = ~s_ff.live_hi;
    end
    // A new count pending wins over the engine taking the old one
    nxt_s.null_pend = cfg_third | wr_strobe | (s_ff.null_pend & ~count_taken_i);
    if (commit && write_i && idx == IDX_IRQ_MASK && byteenable_i[0]) begin
      nxt_s.irq_mask = writedata_i[IRQ_W-1:0];
    end
    // New events win over a same-cycle clear
    nxt_s.irq_stat = (s_ff.irq_stat & ~w1c) | events;
    nxt_s.irq = |(nxt_s.irq_stat & nxt_s.irq_mask);
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_ff <= '0;
      s_ff.waitreq <= 1'b1;
      s_ff.acc <= RST_ACCESS;
      s_ff.mode <= RST_MODE;
      s_ff.bcd <= RST_BCD;
      load_value_ff <= '0;
      load_strobe_ff <= 1'b0;
    end else begin
      s_ff <= nxt_s;
      load_value_ff <= wr_value;
      load_strobe_ff <= wr_strobe;
    end
  end

  assign readdata_o = s_ff.rdata;
  assign waitrequest_o = s_ff.waitreq;
  assign irq_o = s_ff.irq;
  assign load_value_o = load_value_ff;
  assign load_strobe_o = load_strobe_ff;
  assign mode_o = s_ff.mode;
  assign decimal_format_o = s_ff.bcd;
  assign access_o = s_ff.acc;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  property p_cfg_update;
    cfg_third |=> s_ff.mode == mode_t'($past(counting_mode_pick)) &&
      s_ff.bcd == $past(decimal_format_pick) && s_ff.acc == $past(byte_access_pick);
  endproperty
  a_cfg_update: assert property (p_cfg_update) else $error("config not stored");

  property p_count_latch;
    cmd_wr && target_timer_pick == SEL_THIRD && byte_access_pick == ACC_LATCH && !count_held
      |=> count_held;
  endproperty
  a_count_latch: assert property (p_count_latch) else $error("count latch lost");

  property p_rb_status;
    cmd_wr && target_timer_pick == SEL_READBACK && wd[RB_PICK3] && !wd[RB_STATUS_N]
      && !status_held |=> status_held;
  endproperty
  a_rb_status: assert property (p_rb_status) else $error("status latch lost");

  property p_rb_unpicked;
    cmd_wr && target_timer_pick == SEL_READBACK && !wd[RB_PICK3] && !held_any
      |=> !held_any;
  endproperty
  a_rb_unpicked: assert property (p_rb_unpicked) else $error("unpicked counter latched");

  property p_pending_clear;
    count_taken_i && !wr_strobe && !cfg_third |=> !s_ff.null_pend;
  endproperty
  a_pending_clear: assert property (p_pending_clear) else $error("pending not cleared");

  property p_pending_set;
    load_strobe_ff |-> s_ff.null_pend;
  endproperty
  a_pending_set: assert property (p_pending_set) else $error("pending not set");

  property p_live_read;
    req && s_ff.waitreq && read_i && idx == IDX_DATA3 && !held_any && s_ff.acc == ACC_LOW
      |=> !waitrequest_o && readdata_o == {24'h000000, $past(live_count_i[7:0])};
  endproperty
  a_live_read: assert property (p_live_read) else $error("live read wrong");

  property p_latched_read;
    req && s_ff.waitreq && read_i && idx == IDX_DATA3 && status_held
      |=> readdata_o[7:0] == $past(held_byte);
  endproperty
  a_latched_read: assert property (p_latched_read) else $error("latched read wrong");

  property p_one_wait;
    req && s_ff.waitreq |=> !waitrequest_o ##1 waitrequest_o;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("wait timing wrong");

  property p_ignored_flag;
    latch_count && count_held |=> ignored ##1 s_ff.irq_stat[IRQ_IGNORED];
  endproperty
  a_ignored_flag: assert property (p_ignored_flag) else $error("drop not flagged");

  property p_accept_flag;
    latch_status && !status_held |=> s_ff.irq_stat[IRQ_LATCHED];
  endproperty
  a_accept_flag: assert property (p_accept_flag) else $error("latch not flagged");

  property p_rb_count;
    cmd_wr && target_timer_pick == SEL_READBACK && wd[RB_PICK3] && !wd[RB_COUNT_N]
      && !count_held |=> count_held;
  endproperty
  a_rb_count: assert property (p_rb_count) else $error("count latch lost");

  property p_rb_count_skip;
    cmd_wr && target_timer_pick == SEL_READBACK && wd[RB_COUNT_N]
      && !count_held |=> !count_held;
  endproperty
  a_rb_count_skip: assert property (p_rb_count_skip) else $error("count latched");

  property p_other_target;
    cmd_wr && (target_timer_pick == SEL_FIRST || target_timer_pick == SEL_SECOND)
      |=> $stable(s_ff.acc) && $stable(s_ff.mode) && $stable(s_ff.bcd) && $stable(held_any);
  endproperty
  a_other_target: assert property (p_other_target) else $error("other counter hit");

  property p_status_fields;
    latch_status && !status_held |=> held_byte == $past(status_byte);
  endproperty
  a_status_fields: assert property (p_status_fields) else $error("status byte wrong");

  property p_status_pop;
    data_rd && status_held && count_held |=> !status_held && count_held;
  endproperty
  a_status_pop: assert property (p_status_pop) else $error("count lost on status");

  property p_load_pulse;
    wr_strobe |=> load_strobe_ff && load_value_ff == $past(wr_value);
  endproperty
  a_load_pulse: assert property (p_load_pulse) else $error("start value lost");

  property p_live_pair;
    data_rd && !held_any && s_ff.acc == ACC_BOTH |=> s_ff.live_hi != $past(s_ff.live_hi);
  endproperty
  a_live_pair: assert property (p_live_pair) else $error("byte pair stuck");

  property p_cmd_no_read;
    req && s_ff.waitreq && read_i && idx == IDX_CMD |=> readdata_o == '0;
  endproperty
  a_cmd_no_read: assert property (p_cmd_no_read) else $error("command readable");

  c_readback_both: cover property (cmd_wr && target_timer_pick == SEL_READBACK &&
    !wd[RB_COUNT_N] && !wd[RB_STATUS_N] && wd[RB_PICK3]);
  c_pair_write: cover property (data_wr && s_ff.acc == ACC_BOTH ##[1:20] load_strobe_ff);
  c_ignored: cover property (ignored);
  c_irq: cover property (irq_o);
  c_pair_read: cover property (data_rd && held_any && s_ff.acc == ACC_BOTH);
endmodule

// *** counter_cmd_pkg.sv ***
// Constants and types shared by the counter command and read-back logic
package counter_cmd_pkg;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 32;
  // Printed offsets are register indices; byte address is four times the index
  localparam logic [3:0] IDX_DATA3 = 4'h8;
  localparam logic [3:0] IDX_CMD = 4'h9;
  localparam logic [3:0] IDX_IRQ_STAT = 4'ha;
  localparam logic [3:0] IDX_IRQ_MASK = 4'hb;
  localparam int IDX_HI = 5;
  localparam int IDX_LO = 2;
  // Command word fields
  localparam int SEL_HI = 7;
  localparam int SEL_LO = 6;
  localparam int ACC_HI = 5;
  localparam int ACC_LO = 4;
  localparam int MODE_HI = 3;
  localparam int MODE_LO = 1;
  localparam int BCD_BIT = 0;
  localparam int RB_COUNT_N = 5;
  localparam int RB_STATUS_N = 4;
  localparam int RB_PICK3 = 3;
  localparam int RB_PICK2 = 2;
  localparam int RB_PICK1 = 1;
  typedef enum logic [1:0] {
    SEL_FIRST = 2'b00, SEL_SECOND = 2'b01, SEL_THIRD = 2'b10, SEL_READBACK = 2'b11
  } target_t;
  typedef enum logic [1:0] {
    ACC_LATCH = 2'b00, ACC_LOW = 2'b01, ACC_HIGH = 2'b10, ACC_BOTH = 2'b11
  } access_t;
  typedef enum logic [2:0] {
    MODE_TC_IRQ = 3'b000, MODE_ONE_SHOT = 3'b001, MODE_RATE = 3'b010,
    MODE_SQUARE = 3'b011, MODE_SW_STROBE = 3'b100, MODE_HW_STROBE = 3'b101,
    MODE_RSV6 = 3'b110, MODE_RSV7 = 3'b111
  } mode_t;
  localparam access_t RST_ACCESS = ACC_LOW;
  localparam mode_t RST_MODE = MODE_TC_IRQ;
  localparam logic RST_BCD = 1'b0;
  // Interrupt status and mask bits
  localparam int IRQ_W = 3;
  localparam int IRQ_LOADED = 0;
  localparam int IRQ_IGNORED = 1;
  localparam int IRQ_LATCHED = 2;
endpackage

// *** data_port_writer.sv ***
// Assembles data-port writes into start values for the third counter
`timescale 1ns/1ps
module data_port_writer
  import counter_cmd_pkg::*;
(
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic wr_i,
  input wire logic [7:0] byte_i,
  input wire access_t access_i,
  input wire logic restart_i,
  output logic [15:0] value_o,
  output logic strobe_o
);
  typedef struct packed {
    logic hi_next;
    logic [7:0] low_hold;
    logic [15:0] value;
    logic strobe;
  } writer_state_t;
  writer_state_t s_ff, nxt_s;

  always_comb begin
    nxt_s = s_ff;
    nxt_s.strobe = 1'b0;
    if (restart_i) begin
      nxt_s.hi_next = 1'b0;
    end else if (wr_i) begin
      case (access_i)
        ACC_LOW: begin
          nxt_s.value = {8'h00, byte_i};
          nxt_s.strobe = 1'b1;
        end
        ACC_HIGH: begin
          nxt_s.value = {byte_i, 8'h00};
          nxt_s.strobe = 1'b1;
        end
        ACC_BOTH: begin
          if (!s_ff.hi_next) begin
            nxt_s.low_hold = byte_i;
            nxt_s.hi_next = 1'b1;
          end else begin
            nxt_s.value = {byte_i, s_ff.low_hold};
            nxt_s.strobe = 1'b1;
            nxt_s.hi_next = 1'b0;
          end
        end
        default: nxt_s.strobe = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign value_o = s_ff.value;
  assign strobe_o = s_ff.strobe;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  property p_low_load;
    wr_i && !restart_i && access_i == ACC_LOW |=> strobe_o && value_o == {8'h00, $past(byte_i)};
  endproperty
  a_low_load: assert property (p_low_load) else $error("low byte not loaded");
  property p_pair_load;
    wr_i && !restart_i && access_i == ACC_BOTH && s_ff.hi_next
      |=> strobe_o && value_o == {$past(byte_i), $past(s_ff.low_hold)};
  endproperty
  a_pair_load: assert property (p_pair_load) else $error("byte pair misassembled");
endmodule

// *** readback_latch.sv ***
// Holds latched count and status of the third counter until read out
`timescale 1ns/1ps
module readback_latch
  import counter_cmd_pkg::*;
(
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic latch_count_i,
  input wire logic latch_status_i,
  input wire logic [15:0] live_count_i,
  input wire logic [7:0] status_i,
  input wire access_t access_i,
  input wire logic pop_i,
  output logic count_held_o,
  output logic status_held_o,
  output logic [7:0] byte_o,
  output logic ignored_o
);
  typedef struct packed {
    logic sta_v;
    logic [7:0] sta;
    logic cnt_v;
    logic [15:0] cnt;
    logic cnt_hi;
    logic ign;
  } latch_state_t;
  latch_state_t s_ff, nxt_s;

  always_comb begin
    nxt_s = s_ff;
    nxt_s.ign = 1'b0;
    if (pop_i) begin
      if (s_ff.sta_v) begin
        nxt_s.sta_v = 1'b0;
      end else if (s_ff.cnt_v) begin
        if (access_i == ACC_BOTH && !s_ff.cnt_hi) begin
          nxt_s.cnt_hi = 1'b1;
        end else begin
          nxt_s.cnt_v = 1'b0;
          nxt_s.cnt_hi = 1'b0;
        end
      end
    end
    // Only the first latch of each kind counts until it is read
    if (latch_status_i) begin
      if (s_ff.sta_v) begin
        nxt_s.ign = 1'b1;
      end else begin
        nxt_s.sta_v = 1'b1;
        nxt_s.sta = status_i;
      end
    end
    if (latch_count_i) begin
      if (s_ff.cnt_v) begin
        nxt_s.ign = 1'b1;
      end else begin
        nxt_s.cnt_v = 1'b1;
        nxt_s.cnt = live_count_i;
        nxt_s.cnt_hi = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign count_held_o = s_ff.cnt_v;
  assign status_held_o = s_ff.sta_v;
  assign ignored_o = s_ff.ign;
  // Status goes first whatever order the latches arrived in
  assign byte_o = s_ff.sta_v ? s_ff.sta :
    (access_i == ACC_HIGH || (access_i == ACC_BOTH && s_ff.cnt_hi)) ?
    s_ff.cnt[15:8] : s_ff.cnt[7:0];

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  property p_frozen;
    s_ff.cnt_v && !pop_i |=> s_ff.cnt == $past(s_ff.cnt);
  endproperty
  a_frozen: assert property (p_frozen) else $error("latched count changed");
  property p_status_first;
    s_ff.sta_v |-> byte_o == s_ff.sta;
  endproperty
  a_status_first: assert property (p_status_first) else $error("status not first");
  property p_low_then_high;
    pop_i && !s_ff.sta_v && s_ff.cnt_v && access_i == ACC_BOTH && !s_ff.cnt_hi
      |=> s_ff.cnt_v && s_ff.cnt_hi;
  endproperty
  a_low_then_high: assert property (p_low_then_high) else $error("high byte skipped");
endmodule

// *** host_bus_model.sv ***
// Host processor model issuing Avalon-MM register cycles
`timescale 1ns/1ps
module host_bus_model (
  input wire logic clk_i,
  input wire logic waitrequest_i,
  input wire logic [31:0] readdata_i,
  output logic [5:0] address_o,
  output logic read_o,
  output logic write_o,
  output logic [31:0] writedata_o,
  output logic [3:0] byteenable_o
);
  initial begin
    address_o = 6'h00;
    read_o = 1'b0;
    write_o = 1'b0;
    writedata_o = 32'h0;
    byteenable_o = 4'h0;
  end

  // Called just after a rising edge; holds the request until waitrequest is seen low
  task automatic bus(input logic wr, input logic [5:0] a, input logic [7:0] d,
                     output logic [31:0] q);
    int n;
    logic rb;
    logic late;
    n = 0;
    rb = wr && a == 6'h24 && d[7:6] == 2'b11;
    address_o <= a;
    writedata_o <= {24'h0, d[7:1], d[0] & !rb};
    byteenable_o <= 4'h1;
    write_o <= wr;
    read_o <= !wr;
    do begin
      @(posedge clk_i);
      n++;
    end while (waitrequest_i !== 1'b0 && n < 40);
    late = (waitrequest_i !== 1'b0);
    q = readdata_i;
    write_o <= 1'b0;
    read_o <= 1'b0;
    // One idle cycle so no signal is driven twice in one time step
    @(posedge clk_i);
    if (late) begin
      testbench.fail_count++;
      testbench.complete_run();
    end
  endtask
endmodule

// *** testbench.sv ***
// Self-checking bench for the counter command and read-back front end
`timescale 1ns/1ps
module testbench;
  import counter_cmd_pkg::*;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [5:0] address_i;
  logic read_i, write_i, waitrequest_o, irq_o, load_strobe_o, decimal_format_o;
  logic [31:0] writedata_i, readdata_o, q;
  logic [3:0] byteenable_i;
  logic out_level_i = 1'b0;
  logic count_taken_i = 1'b0;
  logic [15:0] live_count_i = 16'h0000;
  logic [15:0] load_value_o;
  logic [2:0] mode_o;
  logic [1:0] access_o;
  int fail_count = 0;
  int n_compared = 0;
  // Reference model state
  int acc = 1, mode = 0, bcd = 0, pend = 0, rtog = 0, wtog = 0, lo_b = 0, irqs = 0, irqm = 0;
  int stq[$];
  int cq[$];

  always #2.5 clk_i = ~clk_i;

  counter_command_readback counter_command_readback_i (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .address_i(address_i), .read_i(read_i),
    .write_i(write_i), .writedata_i(writedata_i), .byteenable_i(byteenable_i),
    .readdata_o(readdata_o), .waitrequest_o(waitrequest_o), .irq_o(irq_o),
    .live_count_i(live_count_i), .out_level_i(out_level_i), .count_taken_i(count_taken_i),
    .load_value_o(load_value_o), .load_strobe_o(load_strobe_o), .mode_o(mode_o),
    .decimal_format_o(decimal_format_o), .access_o(access_o));

  host_bus_model host_bus_model_i (
    .clk_i(clk_i), .waitrequest_i(waitrequest_o), .readdata_i(readdata_o),
    .address_o(address_i), .read_o(read_i), .write_o(write_i),
    .writedata_o(writedata_i), .byteenable_o(byteenable_i));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic complete_run();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  function automatic int stat_byte();
    return {out_level_i, pend[0], acc[1:0], mode[2:0], bcd[0]};
  endfunction

  // A second latch of a kind still unread is dropped and flagged
  task automatic latch(input logic cnt, input logic st);
    if (st && stq.size() != 0) irqs |= 2;
    else if (st) begin
      stq.push_back(stat_byte());
      irqs |= 4;
    end
    if (cnt && cq.size() != 0) irqs |= 2;
    else if (cnt) begin
      if (acc != 2) cq.push_back(live_count_i[7:0]);
      if (acc != 1) cq.push_back(live_count_i[15:8]);
      irqs |= 4;
    end
  endtask

  task automatic cmd(input logic [7:0] c);
    host_bus_model_i.bus(1'b1, 6'h24, c, q);
    if (c[7:6] == 2'b10 && c[5:4] == 2'b00) latch(1'b1, 1'b0);
    else if (c[7:6] == 2'b10) begin
      acc = c[5:4];
      mode = c[3:1];
      bcd = c[0];
      pend = 1;
      rtog = 0;
      wtog = 0;
    end else if (c[7:6] == 2'b11 && c[3]) latch(!c[5], !c[4]);
  endtask

  task automatic rd_data();
    int e;
    host_bus_model_i.bus(1'b0, 6'h20, 8'h00, q);
    if (stq.size() != 0) e = stq.pop_front();
    else if (cq.size() != 0) e = cq.pop_front();
    else begin
      e = (acc == 2 || (acc == 3 && rtog == 1)) ? live_count_i[15:8] : live_count_i[7:0];
      if (acc == 3) rtog = 1 - rtog;
    end
    chk(q, e);
  endtask

  task automatic wr_data(input logic [7:0] d);
    int n;
    logic [15:0] e;
    host_bus_model_i.bus(1'b1, 6'h20, d, q);
    if (acc == 3 && wtog == 0) begin
      lo_b = d;
      wtog = 1;
    end else begin
      for (n = 0; n < 8 && load_strobe_o !== 1'b1; n++) @(posedge clk_i);
      e = acc == 1 ? {8'h00, d} : acc == 2 ? {d, 8'h00} : {d, lo_b[7:0]};
      chk(load_value_o, e);
      chk(load_strobe_o, 1'b1);
      @(posedge clk_i);
      pend = 1;
      wtog = 0;
    end
  endtask

  task automatic irq_chk();
    host_bus_model_i.bus(1'b0, 6'h28, 8'h00, q);
    chk(q, irqs);
    chk(irq_o, (irqs & irqm) != 0);
  endtask

  task automatic new_live();
    live_count_i <= 16'($urandom);
    out_level_i <= 1'($urandom);
    @(posedge clk_i);
  endtask

  initial begin
    q = $urandom(21);
    repeat (5) @(posedge clk_i);
    arst_n_i <= 1'b1;
    @(posedge clk_i);
    chk({waitrequest_o, irq_o, mode_o, decimal_format_o, access_o}, 8'h81);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      cmd({2'b10, 2'(i % 3 + 1), 3'(i), 1'(i % 2)});
      chk({mode_o, decimal_format_o, access_o}, {mode[2:0], bcd[0], acc[1:0]});
    end
    cmd(8'h3a);
    cmd(8'h7c);
    chk({mode_o, decimal_format_o, access_o}, {mode[2:0], bcd[0], acc[1:0]});
    host_bus_model_i.bus(1'b0, 6'h24, 8'h00, q);
    chk(q, 32'h0);
    host_bus_model_i.bus(1'b0, 6'h30, 8'h00, q);
    chk(q, 32'h0);
    $display("test command fields done");
    for (int a = 1; a < 4; a++) begin
      cmd({2'b10, 2'(a), 3'h2, 1'b0});
      new_live();
      rd_data();
      rd_data();
      wr_data(8'($urandom));
      if (a == 3) wr_data(8'($urandom));
    end
    $display("test data port done");
    cmd(8'hb4);
    new_live();
    cmd(8'h84);
    new_live();
    cmd(8'h84);
    cmd(8'he8);
    repeat (3) rd_data();
    cmd(8'h9a);
    new_live();
    cmd(8'hc8);
    cmd(8'hc8);
    rd_data();
    rd_data();
    cmd(8'hc6);
    rd_data();
    cmd(8'ha6);
    new_live();
    cmd(8'hd8);
    rd_data();
    $display("test latch and read-back done");
    wr_data(8'($urandom));
    cmd(8'he8);
    rd_data();
    count_taken_i <= 1'b1;
    @(posedge clk_i);
    count_taken_i <= 1'b0;
    @(posedge clk_i);
    pend = 0;
    irqs |= 1;
    cmd(8'he8);
    rd_data();
    $display("test pending flag done");
    irq_chk();
    host_bus_model_i.bus(1'b1, 6'h2c, 8'h01, q);
    irqm = 1;
    irq_chk();
    host_bus_model_i.bus(1'b1, 6'h28, 8'h01, q);
    irqs &= 6;
    irq_chk();
    host_bus_model_i.bus(1'b1, 6'h2c, 8'h07, q);
    irqm = 7;
    irq_chk();
    host_bus_model_i.bus(1'b1, 6'h28, 8'h07, q);
    irqs = 0;
    irq_chk();
    $display("test interrupts done");
    complete_run();
  end
endmodule
